// ==== hdl/iss_pkg.sv ====
// Purpose: Shared constants and types for the I2C slave data and clock-stretch block
// Assumes: 8-bit bytes, one acknowledge bit per byte
// Notes: Status travels to software as one packed struct
package iss_pkg;

  // Byte framing, counted in rising SCL edges within one byte
  localparam int unsigned ISS_DATA_W = 8;
  localparam logic [3:0] ISS_ACK_BIT = 4'h8;
  localparam logic [3:0] ISS_NINTH_BIT = 4'h9;
  localparam logic [3:0] ISS_BIT_RST = 4'h0;

  // First byte of a 10-bit address carries this marker in its top five bits
  localparam logic [4:0] ISS_TEN_BIT_MARK = 5'h1e;

  // Receive path buffering
  localparam int unsigned ISS_FIFO_DEPTH = 8;

  // Link clock period seen in the bench, for reference only
  localparam int unsigned ISS_LINK_PERIOD_NS = 400;

  // Reset values
  localparam logic [7:0] ISS_BYTE_RST = 8'h00;
  localparam logic ISS_RELEASE_RST = 1'b1;

  typedef enum logic [2:0] {
    ISS_IDLE,
    ISS_ADDR,
    ISS_ADDR_LOW,
    ISS_RX,
    ISS_TX
  } iss_phase_t;

  typedef struct packed {
    logic directionBit;
    logic addressUpdate;
    logic bufferFull;
    logic receiveOverflow;
    logic serialInterrupt;
    logic clockRelease;
  } iss_status_t;

endpackage

// ==== hdl/iss_sync2.sv ====
// Purpose: Two-stage synchroniser for bus pins
// Assumes: Inputs are asynchronous to core_clk
// Notes: Only the second stage may be read outside this module
`timescale 1ns/100ps
`default_nettype none
module iss_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne;

  // Idle bus lines are high, so reset to high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stageOne <= '1;
      syncOut <= '1;
    end else begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end

endmodule // iss_sync2
`default_nettype wire

// ==== hdl/iss_fifo.sv ====
// Purpose: Shift-register FIFO with valid/ready on both sides
// Assumes: Single clock domain
// Notes: Head word and flags come straight from registers
`timescale 1ns/100ps
`default_nettype none
module iss_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] entry [DEPTH];
  logic [CW-1:0] count;
  logic push;
  logic pop;
  logic [CW-1:0] next_count;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = entry[0];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      count <= next_count;
      inReady <= (next_count != FULL_CNT);
      outValid <= (next_count != '0);
    end
  end

  // Each slot takes its neighbour on a pop, or the new word at the write position
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge core_clk) begin
      if (srst) begin
        entry[i] <= '0;
      end else if (push && (CW'(i) == (pop ? count - 1'b1 : count))) begin
        entry[i] <= inData;
      end else if (pop) begin
        entry[i] <= (i + 1 < DEPTH) ? entry[(i + 1) % DEPTH] : '0;
      end
    end
  end

endmodule // iss_fifo
`default_nettype wire

// ==== hdl/iss_data_stretch.sv ====
// Purpose: I2C slave data phase with acknowledge and clock stretching
// Assumes: SCL and SDA are open drain; the master keeps the link's timing
// Notes: Received bytes queue in an 8-word FIFO that stands for the data buffer
`timescale 1ns/100ps
`default_nettype none
module iss_data_stretch (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  // Configuration
  input wire logic tenBitMode,
  input wire logic receiveStretchEnable,
  input wire logic [7:0] ownAddress,
  input wire logic ownAddressWrite,
  // Software control pulses
  input wire logic setClockRelease,
  input wire logic clearInterrupt,
  input wire logic clearOverflow,
  // Transmit data
  input wire logic [7:0] txData,
  input wire logic txWrite,
  // Receive data stream
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  // Status
  output iss_pkg::iss_status_t status
);

  logic sclS;
  logic sdaS;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  iss_pkg::iss_phase_t phase;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txShift;
  logic seenTen;
  logic ackDrive;
  logic irqArm;
  logic byteWasData;
  logic masterNack;
  logic txLoaded;
  logic uaStretch;

  logic directionBit;
  logic addressUpdate;
  logic receiveOverflow;
  logic serialInterrupt;
  logic clockRelease;
  logic bufferFull;

  logic pushValid;
  logic [7:0] pushData;
  logic fifoInReady;

  logic ackFall;
  logic ninthFall;
  logic ninthRise;
  logic addrHit;
  logic lowHit;
  logic overflowCond;
  logic accept;
  logic ackGive;
  logic stretchReq;
  logic rxStretch;
  logic txStretch;

  iss_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .asyncIn({sclIn, sdaIn}),
    .syncOut({sclS, sdaS})
  );

  // Received bytes and addresses wait here; outside transmit a full queue is the buffer-full state
  iss_fifo #(
    .WIDTH(iss_pkg::ISS_DATA_W),
    .DEPTH(iss_pkg::ISS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

  // Edge and condition detection on the synchronised lines
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;
  assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopSeen = sclS && sclPrev && !sdaPrev && sdaS;

  assign ackFall = sclFall && (bitCnt == iss_pkg::ISS_ACK_BIT) && (phase != iss_pkg::ISS_IDLE);
  assign ninthFall = sclFall && (bitCnt == iss_pkg::ISS_NINTH_BIT);
  assign ninthRise = sclRise && (bitCnt == iss_pkg::ISS_ACK_BIT);

  // Upper seven bits against the own address; the same compare serves the 10-bit high byte
  assign addrHit = (shiftIn[7:1] == ownAddress[7:1]);
  assign lowHit = (shiftIn == ownAddress);
  assign overflowCond = !fifoInReady || receiveOverflow;

  always_comb begin
    case (phase)
      iss_pkg::ISS_ADDR: begin
        // A 10-bit read header only counts after the full address was seen
        accept = addrHit && (!tenBitMode || !shiftIn[0] || seenTen)
          && (!tenBitMode || (shiftIn[7:3] == iss_pkg::ISS_TEN_BIT_MARK));
      end
      iss_pkg::ISS_ADDR_LOW: accept = lowHit;
      iss_pkg::ISS_RX: accept = 1'b1;
      default: accept = 1'b0;
    endcase
  end

  assign ackGive = accept && !overflowCond;

  // Byte framing: sample on rise, count bits, restart on START
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bitCnt <= iss_pkg::ISS_BIT_RST;
      shiftIn <= iss_pkg::ISS_BYTE_RST;
    end else if (startSeen || stopSeen || (phase == iss_pkg::ISS_IDLE)) begin
      bitCnt <= iss_pkg::ISS_BIT_RST;
    end else if (ninthFall) begin
      bitCnt <= iss_pkg::ISS_BIT_RST;
    end else if (sclRise && (bitCnt < iss_pkg::ISS_NINTH_BIT)) begin
      bitCnt <= bitCnt + 4'h1;
      if (bitCnt < iss_pkg::ISS_ACK_BIT) begin
        shiftIn <= {shiftIn[6:0], sdaS};
      end
    end
  end

  // Transfer phase
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase <= iss_pkg::ISS_IDLE;
      seenTen <= 1'b0;
    end else if (stopSeen) begin
      phase <= iss_pkg::ISS_IDLE;
      seenTen <= 1'b0;
    end else if (startSeen) begin
      // A repeated START keeps the 10-bit match for the read header
      phase <= iss_pkg::ISS_ADDR;
    end else if (ackFall) begin
      case (phase)
        iss_pkg::ISS_ADDR: begin
          if (!ackGive) begin
            phase <= iss_pkg::ISS_IDLE;
          end else if (shiftIn[0]) begin
            phase <= iss_pkg::ISS_TX;
          end else if (tenBitMode) begin
            phase <= iss_pkg::ISS_ADDR_LOW;
            seenTen <= 1'b0;
          end else begin
            phase <= iss_pkg::ISS_RX;
          end
        end
        iss_pkg::ISS_ADDR_LOW: begin
          phase <= ackGive ? iss_pkg::ISS_RX : iss_pkg::ISS_IDLE;
          seenTen <= ackGive;
        end
        default: phase <= phase;
      endcase
    end else if (ninthFall && masterNack) begin
      phase <= iss_pkg::ISS_IDLE;
    end
  end

  // Acknowledge drive, interrupt arming and byte bookkeeping
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ackDrive <= 1'b0;
      irqArm <= 1'b0;
      byteWasData <= 1'b0;
      masterNack <= 1'b0;
    end else if (startSeen || stopSeen) begin
      ackDrive <= 1'b0;
      irqArm <= 1'b0;
      byteWasData <= 1'b0;
      masterNack <= 1'b0;
    end else if (ackFall) begin
      ackDrive <= ackGive;
      irqArm <= accept || (phase == iss_pkg::ISS_TX);
      byteWasData <= (phase == iss_pkg::ISS_RX) || (phase == iss_pkg::ISS_TX);
    end else if (ninthRise && (phase == iss_pkg::ISS_TX) && byteWasData) begin
      masterNack <= sdaS;
    end else if (ninthFall) begin
      ackDrive <= 1'b0;
      irqArm <= 1'b0;
      masterNack <= 1'b0;
    end
  end

  // Queue the accepted byte, address bytes included
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pushValid <= 1'b0;
      pushData <= iss_pkg::ISS_BYTE_RST;
    end else begin
      pushValid <= ackFall && ackGive;
      pushData <= shiftIn;
    end
  end

  // Direction status
  always_ff @(posedge core_clk) begin
    if (srst) begin
      directionBit <= 1'b0;
    end else if (ninthRise && (phase == iss_pkg::ISS_TX) && byteWasData && sdaS) begin
      directionBit <= 1'b0;
    end else if (ackFall && ackGive && (phase == iss_pkg::ISS_ADDR)) begin
      directionBit <= shiftIn[0];
    end
  end

  // Transmit byte: a write loads the shift register, bits move on falling SCL
  always_ff @(posedge core_clk) begin
    if (srst) begin
      txShift <= iss_pkg::ISS_BYTE_RST;
      txLoaded <= 1'b0;
    end else if (txWrite) begin
      txShift <= txData;
      txLoaded <= 1'b1;
    end else begin
      if (ninthRise && (phase == iss_pkg::ISS_TX) && byteWasData && sdaS) begin
        txLoaded <= 1'b0;
      end else if (ackFall && (phase == iss_pkg::ISS_TX)) begin
        txLoaded <= 1'b0;
      end
      if (sclFall && (phase == iss_pkg::ISS_TX) && (bitCnt != iss_pkg::ISS_BIT_RST)
          && (bitCnt < iss_pkg::ISS_ACK_BIT)) begin
        txShift <= {txShift[6:0], 1'b0};
      end
    end
  end

  // Address-update flag; a new event beats a same-cycle address write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addressUpdate <= 1'b0;
    end else if (ackFall && ackGive && tenBitMode
        && (((phase == iss_pkg::ISS_ADDR) && !shiftIn[0]) || (phase == iss_pkg::ISS_ADDR_LOW))) begin
      addressUpdate <= 1'b1;
    end else if (ownAddressWrite || stopSeen) begin
      addressUpdate <= 1'b0;
    end else if (ninthRise && (phase == iss_pkg::ISS_TX) && byteWasData && sdaS) begin
      addressUpdate <= 1'b0;
    end
  end

  // Address stretch that leaves the release bit alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      uaStretch <= 1'b0;
    end else if (ownAddressWrite || stopSeen) begin
      uaStretch <= 1'b0;
    end else if (ninthFall && addressUpdate) begin
      uaStretch <= 1'b1;
    end
  end

  // Stretch decisions at the ninth falling edge on buffer state; receive only after data bytes, transmit after the read address too
  assign rxStretch = byteWasData && (phase == iss_pkg::ISS_RX) && receiveStretchEnable
    && !fifoInReady;
  assign txStretch = (phase == iss_pkg::ISS_TX) && !masterNack && !txLoaded;

  // Release bit: a software set wins over the automatic clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clockRelease <= iss_pkg::ISS_RELEASE_RST;
    end else if (setClockRelease) begin
      clockRelease <= 1'b1;
    end else if (ninthFall && (rxStretch || txStretch)) begin
      clockRelease <= 1'b0;
    end
  end

  // Interrupt flag: hardware set wins over software clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      serialInterrupt <= 1'b0;
    end else if (ninthFall && irqArm) begin
      serialInterrupt <= 1'b1;
    end else if (clearInterrupt) begin
      serialInterrupt <= 1'b0;
    end
  end

  // Overflow flag: a data byte arriving with the buffer full is lost and flagged
  always_ff @(posedge core_clk) begin
    if (srst) begin
      receiveOverflow <= 1'b0;
    end else if (ackFall && (phase == iss_pkg::ISS_RX) && !fifoInReady) begin
      receiveOverflow <= 1'b1;
    end else if (clearOverflow) begin
      receiveOverflow <= 1'b0;
    end
  end

  // Buffer-full shows the transmit load while sending, the full queue otherwise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bufferFull <= 1'b0;
    end else begin
      bufferFull <= (phase == iss_pkg::ISS_TX) ? txLoaded : !fifoInReady;
    end
  end

  assign stretchReq = !clockRelease || uaStretch;

  // SCL drive: start pulling only once the line is seen low, so the master always
  // leads the low phase; dropping the drive lets the line rise only when all let go
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclOe <= 1'b0;
    end else begin
      sclOe <= stretchReq && (sclOe || !sclS);
    end
  end

  // SDA drive: acknowledge slot or a zero data bit while sending
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sdaOe <= 1'b0;
    end else begin
      sdaOe <= ackDrive || ((phase == iss_pkg::ISS_TX) && (bitCnt < iss_pkg::ISS_ACK_BIT)
        && !masterNack && !txShift[7]);
    end
  end

  // Open-drain outputs only ever pull low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status <= '0;
      status.clockRelease <= iss_pkg::ISS_RELEASE_RST;
    end else begin
      status.directionBit <= directionBit;
      status.addressUpdate <= addressUpdate;
      status.bufferFull <= bufferFull;
      status.receiveOverflow <= receiveOverflow;
      status.serialInterrupt <= serialInterrupt;
      status.clockRelease <= clockRelease;
    end
  end

endmodule // iss_data_stretch
`default_nettype wire

// ==== testbench/iss_data_stretch_props.sv ====
// Purpose: Concurrent checks on the slave data and clock-stretch block
// Assumes: One clock domain; pins pass a two-flop synchroniser
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module iss_data_stretch_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins
  input wire logic sclIn,
  input wire logic sclOe,
  input wire logic sdaOe,
  // Software pulses
  input wire logic setClockRelease,
  input wire logic clearInterrupt,
  input wire logic clearOverflow,
  input wire logic ownAddressWrite,
  // Stream and status
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire iss_pkg::iss_status_t status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Cycles since software last freed the clock
  logic [3:0] relAge;
  always_ff @(posedge core_clk) begin
    if (srst || setClockRelease || ownAddressWrite) relAge <= 4'h0;
    else if (relAge != 4'hf) relAge <= relAge + 4'h1;
  end
  a_reset_state: assert property (@(posedge core_clk) disable iff (1'b0)
    srst |=> !sclOe && !sdaOe && !rxValid && status == 6'h01)
    else $error("outputs not at reset values");
  a_stretch_after_low: assert property ($rose(sclOe) |-> !$past(sclIn, 1) && !$past(sclIn, 2))
    else $error("SCL pulled before it was seen low");
  a_release_cause: assert property ($fell(sclOe) |-> relAge < 4'h8)
    else $error("stretch ended without a software release");
  a_ack_no_room: assert property (!status.directionBit && status.receiveOverflow
    && $past(status.receiveOverflow, 4) |-> !$rose(sdaOe))
    else $error("acknowledge given while overflow set");
  a_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
    else $error("buffer head lost before it was read");
  a_irq_sticky: assert property ($fell(status.serialInterrupt) |->
    $past(clearInterrupt, 1) || $past(clearInterrupt, 2) || $past(clearInterrupt, 3))
    else $error("interrupt flag cleared by itself");
  a_ovf_sticky: assert property ($fell(status.receiveOverflow) |->
    $past(clearOverflow, 1) || $past(clearOverflow, 2) || $past(clearOverflow, 3))
    else $error("overflow flag cleared by itself");
  // A change shows one cycle after launch, by when a free master may have raised SCL
  a_sda_scl_low: assert property ($changed(sdaOe) |-> !$past(sclIn, 1) && !$past(sclIn, 2))
    else $error("SDA changed while SCL high");
endmodule // iss_data_stretch_props
bind iss_data_stretch iss_data_stretch_props u_props (.core_clk(core_clk), .srst(srst),
  .sclIn(sclIn), .sclOe(sclOe), .sdaOe(sdaOe), .setClockRelease(setClockRelease),
  .clearInterrupt(clearInterrupt), .clearOverflow(clearOverflow),
  .ownAddressWrite(ownAddressWrite), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
  .status(status));
`default_nettype wire

// ==== testbench/iss_i2c_master.sv ====
// Purpose: Behavioural I2C bus master driving the slave's pins
// Assumes: Open-drain lines with pull-ups resolved by the bench
// Notes: SCL stands still outside frames; tasks are called by the bench
`timescale 1ns/100ps
`default_nettype none
module iss_i2c_master (
  // High while the master pulls a line low
  output logic sclLow,
  output logic sdaLow,
  // Resolved line levels
  input wire logic sclLine,
  input wire logic sdaLine
);
  localparam int HALF = 200;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // A slave stretch is waited out, bounded so a stuck slave cannot hang us
  task automatic wait_high();
    int n;
    n = 0;
    sclLow = 1'b0;
    while (sclLine !== 1'b1 && n < 8000) begin
      #50;
      n = n + 1;
    end
  endtask
  // SDA moves mid-low so it never races the SCL fall
  task automatic bitx(input logic v, output logic s);
    #(HALF / 2);
    sdaLow = !v;
    #(HALF / 2);
    wait_high();
    #(HALF / 2);
    s = sdaLine;
    #(HALF / 2);
    sclLow = 1'b1;
  endtask
  task automatic start();
    sdaLow = 1'b1;
    #HALF;
    sclLow = 1'b1;
  endtask
  task automatic stop();
    #(HALF / 2);
    sdaLow = 1'b1;
    #(HALF / 2);
    wait_high();
    #HALF;
    sdaLow = 1'b0;
    #HALF;
  endtask
  task automatic restart();
    #(HALF / 2);
    sdaLow = 1'b0;
    #(HALF / 2);
    wait_high();
    #HALF;
    start();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(nack, s);
  endtask
endmodule // iss_i2c_master
`default_nettype wire

// ==== testbench/iss_data_stretch_test.sv ====
// Purpose: Self-checking bench for the slave data and clock-stretch block
// Assumes: Master model on the pins, software pulses from this bench
// Notes: Received bytes are checked in order against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module iss_data_stretch_test;
  logic core_clk, srst, sclIn, sdaIn, sclOut, sclOe, sdaOut, sdaOe, ack;
  logic tenBitMode, receiveStretchEnable, ownAddressWrite, setClockRelease, clearInterrupt;
  logic clearOverflow, txWrite, rxValid, rxReady, mSclLow, mSdaLow;
  logic [7:0] ownAddress, txData, rxData, d, got;
  iss_pkg::iss_status_t status;
  logic [7:0] rxExp[$];
  int err_total = 0, num_checks = 0, cyc = 0;
  assign sclIn = !(mSclLow || sclOe);
  assign sdaIn = !(mSdaLow || sdaOe);
  iss_data_stretch u_dut (.core_clk(core_clk), .srst(srst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .tenBitMode(tenBitMode),
    .receiveStretchEnable(receiveStretchEnable), .ownAddress(ownAddress),
    .ownAddressWrite(ownAddressWrite), .setClockRelease(setClockRelease),
    .clearInterrupt(clearInterrupt), .clearOverflow(clearOverflow), .txData(txData),
    .txWrite(txWrite), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .status(status));
  iss_i2c_master u_mst (.sclLow(mSclLow), .sdaLow(mSdaLow), .sclLine(sclIn), .sdaLine(sdaIn));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = !core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Pulses: release, clear interrupt, clear overflow, address rewrite
  task automatic sw(input logic [3:0] p);
    @(negedge core_clk);
    {setClockRelease, clearInterrupt, clearOverflow, ownAddressWrite} = p;
    @(negedge core_clk);
    {setClockRelease, clearInterrupt, clearOverflow, ownAddressWrite} = 4'h0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((rxValid !== 1'b0 || rxExp.size() != 0) && n < 400) begin
      @(negedge core_clk);
      rxReady = 1'($urandom);
      n++;
    end
    @(negedge core_clk);
    rxReady = 1'b0;
    chk({7'h0, rxValid}, 8'h00);
    chk(8'(rxExp.size()), 8'h00);
    chk({6'h0, sclOut, sdaOut}, 8'h00);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (!srst && rxValid === 1'b1 && rxReady === 1'b1) begin
      if (rxExp.size() == 0) chk(rxData, 8'hxx);
      else chk(rxData, rxExp.pop_front());
    end
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h533d5447));
    {srst, receiveStretchEnable} = 2'h3;
    {tenBitMode, ownAddressWrite, setClockRelease, clearInterrupt, clearOverflow} = 5'h00;
    {txWrite, rxReady, ownAddress, txData} = {2'h0, 8'ha0, 8'h00};
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    settle();
    // Foreign address is ignored
    u_mst.start();
    u_mst.wbyte(8'h44, ack);
    chk({7'h0, ack}, 8'h01);
    u_mst.stop();
    // Address plus seven data bytes fill the buffer; the last one stretches
    u_mst.start();
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'ha0 : 8'($urandom);
      u_mst.wbyte(d, ack);
      rxExp.push_back(d);
      settle();
      chk({7'h0, ack}, 8'h00);
      chk({7'h0, status.directionBit}, 8'h00);
      chk({7'h0, status.serialInterrupt}, 8'h01);
      chk({6'h0, status.bufferFull, status.clockRelease}, {6'h0, i == 7, i != 7});
      chk({7'h0, sclOe}, {7'h0, i == 7});
      sw(4'b0100);
    end
    sw(4'b1000);
    chk({7'h0, status.clockRelease}, 8'h01);
    u_mst.wbyte(8'h5a, ack);
    settle();
    chk({7'h0, ack}, 8'h01);
    chk({7'h0, status.receiveOverflow}, 8'h01);
    sw(4'b1100);
    u_mst.stop();
    drain();
    // Empty buffer but overflow still set: the next byte is refused
    u_mst.start();
    u_mst.wbyte(8'ha0, ack);
    chk({7'h0, ack}, 8'h01);
    u_mst.stop();
    sw(4'b0010);
    chk({7'h0, status.receiveOverflow}, 8'h00);
    // Read: address stretches, two bytes out, master refuses the second
    // Receive stretch off: transmit must stretch all the same
    receiveStretchEnable = 1'b0;
    u_mst.start();
    u_mst.wbyte(8'ha1, ack);
    rxExp.push_back(8'ha1);
    settle();
    chk({7'h0, ack}, 8'h00);
    chk({6'h0, status.directionBit, status.clockRelease}, 8'h02);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      @(negedge core_clk);
      {txData, txWrite} = {d, 1'b1};
      @(negedge core_clk);
      txWrite = 1'b0;
      sw(4'b1100);
      chk({7'h0, status.bufferFull}, 8'h01);
      u_mst.rbyte(i == 1, got);
      settle();
      chk(got, d);
      chk({7'h0, status.serialInterrupt}, 8'h01);
      chk({7'h0, status.directionBit}, {7'h0, i == 0});
      if (i == 0) chk({7'h0, status.clockRelease}, 8'h00);
    end
    sw(4'b1100);
    u_mst.stop();
    drain();
    // Ten-bit address: each address byte waits for the address rewrite
    {tenBitMode, receiveStretchEnable} = 2'h3;
    ownAddress = 8'hf2;
    u_mst.start();
    u_mst.wbyte(8'hf2, ack);
    rxExp.push_back(8'hf2);
    settle();
    chk({7'h0, ack}, 8'h00);
    chk({5'h0, status.addressUpdate, sclOe, status.clockRelease}, 8'h07);
    ownAddress = 8'h34;
    sw(4'b0101);
    chk({6'h0, status.addressUpdate, sclOe}, 8'h00);
    u_mst.wbyte(8'h34, ack);
    rxExp.push_back(8'h34);
    settle();
    chk({6'h0, status.addressUpdate, ack}, 8'h02);
    ownAddress = 8'hf2;
    sw(4'b0101);
    // Repeated START with the high byte and read: buffer-state stretch only
    u_mst.restart();
    u_mst.wbyte(8'hf3, ack);
    rxExp.push_back(8'hf3);
    settle();
    chk({7'h0, ack}, 8'h00);
    chk({5'h0, status.addressUpdate, status.directionBit, status.clockRelease}, 8'h02);
    d = 8'($urandom);
    @(negedge core_clk);
    {txData, txWrite} = {d, 1'b1};
    @(negedge core_clk);
    txWrite = 1'b0;
    sw(4'b1100);
    u_mst.rbyte(1'b1, got);
    settle();
    chk(got, d);
    sw(4'b1100);
    u_mst.stop();
    drain();
    final_report();
  end
endmodule // iss_data_stretch_test
`default_nettype wire
